// *** design/brdc_pkg.sv ***
// Package for the bridge range decode and configuration registers.
// Assumes a single 100 MHz clock domain and a plain register port.
package brdc_pkg;
    // Register indices; byte address on the register port is index times four
    localparam logic [7:0] OFF_ERR_STATUS = 8'h71;
    localparam logic [7:0] OFF_MEM_GAP = 8'h78;
    localparam logic [7:0] OFF_MEM_GAP_UPPER = 8'h7a;
    localparam logic [7:0] OFF_FRAME_BUF = 8'h7c;
    localparam logic [7:0] OFF_HIGH_GAP_START = 8'h88;
    localparam logic [7:0] OFF_HIGH_GAP_END = 8'h8c;
    localparam logic [7:0] OFF_IO_WIN_ONE = 8'h98;
    localparam logic [7:0] OFF_PCI_RESET_CTL = 8'h9c;
    localparam logic [7:0] OFF_IO_WIN_TWO = 8'ha0;
    localparam int ADDR_W = 10;

    // Writable bit masks; ERR_MASK holds the event-set, write-one-to-clear error flags (reserved bits read zero)
    localparam logic [7:0] ERR_MASK = 8'h71;
    localparam logic [15:0] MEM_GAP_MASK = 16'hfcf0;
    localparam logic [15:0] MEM_GAP_UPPER_MASK = 16'h0fff;
    localparam logic [31:0] FRAME_BUF_MASK = 32'hfff01a9f;
    localparam logic [31:0] HIGH_GAP_START_MASK = 32'h8000ffff;
    localparam logic [31:0] HIGH_GAP_END_MASK = 32'h0000ffff;
    localparam logic [31:0] IO_WIN_MASK = 32'hfff0fff1;
    localparam logic [7:0] PCI_RESET_MASK = 8'h01;

    // Reset values
    localparam logic [31:0] IO_WIN_RESET_COMPAT = 32'hfff00001;
    localparam logic [31:0] IO_WIN_RESET_AUX = 32'hfff00000;

    // Error status flag positions
    localparam int ERR_SHUTDOWN_BIT = 0;
    localparam int ERR_ADDR_PAR_BIT = 4;
    localparam int ERR_RD_PAR_BIT = 5;
    localparam int ERR_WR_PAR_BIT = 6;

    // Field positions
    localparam int MG_EN_BIT = 15;
    localparam int MG_SIZE_LSB = 10;
    localparam int MG_START_LSB = 4;
    localparam int FB_START_LSB = 20;
    localparam int FB_VGA_BIT = 12;
    localparam int FB_EN_BIT = 11;
    localparam int FB_NOLOCK_BIT = 9;
    localparam int FB_NOFLUSH_BIT = 7;
    localparam int HG_EN_BIT = 31;
    localparam int IO_END_LSB = 20;
    localparam int IO_START_LSB = 4;
    localparam int IO_EN_BIT = 0;

    // Size codes: FB codes are the mask of address bits A[24:20] ignored in the compare; MG codes are decoded to that mask
    localparam logic [4:0] MG_SZ_1M = 5'h00;
    localparam logic [4:0] MG_SZ_2M = 5'h04;
    localparam logic [4:0] MG_SZ_4M = 5'h0c;
    localparam logic [4:0] MG_SZ_8M = 5'h1c;
    localparam logic [4:0] MG_SZ_16M = 5'h1e;
    localparam logic [4:0] MG_SZ_32M = 5'h1f;
    localparam logic [4:0] FB_SZ_1M = 5'h00;
    localparam logic [4:0] FB_SZ_2M = 5'h01;
    localparam logic [4:0] FB_SZ_4M = 5'h03;
    localparam logic [4:0] FB_SZ_8M = 5'h07;
    localparam logic [4:0] FB_SZ_16M = 5'h0f;
    localparam logic [4:0] FB_SZ_32M = 5'h1f;

    // VGA window A0000-BFFFF: A[35:17] compare value
    localparam logic [18:0] VGA_BASE_A17 = 19'h00005;
    localparam logic [18:0] VGA_MASK_A17 = 19'h7ffff;

    // PCI reset pulse timing
    localparam int PCI_RST_US = 1000;
    localparam int CLK_MHZ = 100;
    localparam int PCI_RST_CYCLES = PCI_RST_US * CLK_MHZ;

    // Host request and routing answer
    typedef struct packed {
        logic valid;
        logic is_io;
        logic locked;
        logic deferred;
        logic [35:0] addr;
    } brdc_req_t;

    typedef struct packed {
        logic to_pci;
        logic exclusive;
        logic flush_inbound;
    } brdc_route_t;

    typedef enum logic [1:0] {
        BRDC_RST_POWER = 2'b00,
        BRDC_RST_IDLE = 2'b01,
        BRDC_RST_PULSE = 2'b10
    } brdc_rst_state_t;
endpackage : brdc_pkg

// *** design/brdc_top.sv ***
// Range decode, error status and PCI reset control of a host-to-PCI bridge.
// Assumes one clock, synchronous inputs and a plain register port.
`timescale 1ns/100ps
`default_nettype none
module brdc_top #(
    parameter bit COMPAT = 1'b1,
    parameter int RST_CYCLES = brdc_pkg::PCI_RST_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [brdc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    input wire logic ev_wr_perr,
    input wire logic ev_rd_par_bad,
    input wire logic ev_addr_par_bad,
    input wire logic ev_shutdown,
    input wire logic init_on_shutdown,
    output logic init_req,
    input wire brdc_pkg::brdc_req_t host_req,
    output brdc_pkg::brdc_route_t host_route,
    input wire brdc_pkg::brdc_req_t pci_req,
    output logic pci_to_host,
    output logic pci_reset_out_n
);
    // Elaboration check on the pulse length
    if (RST_CYCLES < 1) begin : g_bad_rst_cycles
        $error("RST_CYCLES must be at least one");
    end

    logic [7:0] err_r;
    logic [15:0] mg_r;
    logic [15:0] mgu_r;
    logic [31:0] fb_r;
    logic [31:0] hgs_r;
    logic [31:0] hge_r;
    logic [31:0] io1_r;
    logic [31:0] io2_r;
    logic [7:0] prst_r;
    logic [31:0] rdata_r;

    // Register address decode (index times four)
    function automatic logic hit(input logic [brdc_pkg::ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction : hit

    wire logic wr_err = reg_wr && hit(reg_addr, brdc_pkg::OFF_ERR_STATUS);
    wire logic wr_mg = reg_wr && hit(reg_addr, brdc_pkg::OFF_MEM_GAP);
    wire logic wr_mgu = reg_wr && hit(reg_addr, brdc_pkg::OFF_MEM_GAP_UPPER);
    wire logic wr_fb = reg_wr && hit(reg_addr, brdc_pkg::OFF_FRAME_BUF);
    wire logic wr_hgs = reg_wr && hit(reg_addr, brdc_pkg::OFF_HIGH_GAP_START);
    wire logic wr_hge = reg_wr && hit(reg_addr, brdc_pkg::OFF_HIGH_GAP_END);
    wire logic wr_io1 = reg_wr && hit(reg_addr, brdc_pkg::OFF_IO_WIN_ONE);
    wire logic wr_prst = reg_wr && hit(reg_addr, brdc_pkg::OFF_PCI_RESET_CTL);
    wire logic wr_io2 = reg_wr && hit(reg_addr, brdc_pkg::OFF_IO_WIN_TWO);

    // Error events; set wins over clear
    wire logic [7:0] err_set = ({7'h00, ev_shutdown && COMPAT} << brdc_pkg::ERR_SHUTDOWN_BIT)
        | ({7'h00, ev_addr_par_bad} << brdc_pkg::ERR_ADDR_PAR_BIT)
        | ({7'h00, ev_rd_par_bad} << brdc_pkg::ERR_RD_PAR_BIT)
        | ({7'h00, ev_wr_perr} << brdc_pkg::ERR_WR_PAR_BIT);
    wire logic [7:0] err_clr = wr_err ? reg_wdata[7:0] : 8'h00;
    wire logic [7:0] err_nxt = ((err_r & ~err_clr) | err_set) & brdc_pkg::ERR_MASK;

    localparam logic [31:0] IO_RST_VAL = COMPAT ? brdc_pkg::IO_WIN_RESET_COMPAT : brdc_pkg::IO_WIN_RESET_AUX;

    // Read mux, reserved bits masked to zero
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit(reg_addr, brdc_pkg::OFF_ERR_STATUS)) rd_mux = {24'h0, err_r};
        if (hit(reg_addr, brdc_pkg::OFF_MEM_GAP)) rd_mux = {16'h0, mg_r};
        if (hit(reg_addr, brdc_pkg::OFF_MEM_GAP_UPPER)) rd_mux = {16'h0, mgu_r};
        if (hit(reg_addr, brdc_pkg::OFF_FRAME_BUF)) rd_mux = fb_r;
        if (hit(reg_addr, brdc_pkg::OFF_HIGH_GAP_START)) rd_mux = hgs_r;
        if (hit(reg_addr, brdc_pkg::OFF_HIGH_GAP_END)) rd_mux = hge_r;
        if (hit(reg_addr, brdc_pkg::OFF_IO_WIN_ONE)) rd_mux = io1_r;
        if (hit(reg_addr, brdc_pkg::OFF_PCI_RESET_CTL)) rd_mux = {24'h0, prst_r};
        if (hit(reg_addr, brdc_pkg::OFF_IO_WIN_TWO)) rd_mux = io2_r;
    end

    // Register file
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            err_r <= 8'h00;
            mg_r <= 16'h0000;
            mgu_r <= 16'h0000;
            fb_r <= 32'h0000_0000;
            hgs_r <= 32'h0000_0000;
            hge_r <= 32'h0000_0000;
            io1_r <= IO_RST_VAL;
            io2_r <= IO_RST_VAL;
            prst_r <= 8'h00;
            rdata_r <= 32'h0000_0000;
        end else begin
            err_r <= err_nxt;
            if (wr_mg) mg_r <= reg_wdata[15:0] & brdc_pkg::MEM_GAP_MASK;
            if (wr_mgu) mgu_r <= reg_wdata[15:0] & brdc_pkg::MEM_GAP_UPPER_MASK;
            if (wr_fb) fb_r <= reg_wdata & brdc_pkg::FRAME_BUF_MASK;
            if (wr_hgs) hgs_r <= reg_wdata & brdc_pkg::HIGH_GAP_START_MASK;
            if (wr_hge) hge_r <= reg_wdata & brdc_pkg::HIGH_GAP_END_MASK;
            if (wr_io1) io1_r <= reg_wdata & brdc_pkg::IO_WIN_MASK;
            if (wr_io2) io2_r <= reg_wdata & brdc_pkg::IO_WIN_MASK;
            if (wr_prst) prst_r <= reg_wdata[7:0] & brdc_pkg::PCI_RESET_MASK;
            rdata_r <= reg_rd ? rd_mux : 32'h0000_0000;
        end
    end
    assign reg_rdata = rdata_r;

    // Size code to A[24:20] don't-care mask
    function automatic logic [4:0] mg_size_mask(input logic [4:0] code);
        case (code)
            brdc_pkg::MG_SZ_1M: mg_size_mask = 5'h00;
            brdc_pkg::MG_SZ_2M: mg_size_mask = 5'h01;
            brdc_pkg::MG_SZ_4M: mg_size_mask = 5'h03;
            brdc_pkg::MG_SZ_8M: mg_size_mask = 5'h07;
            brdc_pkg::MG_SZ_16M: mg_size_mask = 5'h0f;
            brdc_pkg::MG_SZ_32M: mg_size_mask = 5'h1f;
            default: mg_size_mask = 5'h00;
        endcase
    endfunction : mg_size_mask

    function automatic logic [4:0] fb_size_mask(input logic [4:0] code);
        case (code)
            brdc_pkg::FB_SZ_1M: fb_size_mask = 5'h00;
            brdc_pkg::FB_SZ_2M: fb_size_mask = 5'h01;
            brdc_pkg::FB_SZ_4M: fb_size_mask = 5'h03;
            brdc_pkg::FB_SZ_8M: fb_size_mask = 5'h07;
            brdc_pkg::FB_SZ_16M: fb_size_mask = 5'h0f;
            brdc_pkg::FB_SZ_32M: fb_size_mask = 5'h1f;
            default: fb_size_mask = 5'h00;
        endcase
    endfunction : fb_size_mask

    // Memory gap: base A[35:20] from upper and lower registers
    wire logic [3:0] mg_start = mg_r[brdc_pkg::MG_START_LSB +: 4];
    wire logic [15:0] mg_base = {mgu_r[11:0], mg_start};
    wire logic [15:0] mg_dc = {11'h000, mg_size_mask(mg_r[brdc_pkg::MG_SIZE_LSB +: 5])};
    wire logic mg_on = mg_r[brdc_pkg::MG_EN_BIT] && (mg_start != 4'h0);
    function automatic logic mg_hit(input logic [35:0] a);
        mg_hit = mg_on && (((a[35:20] ^ mg_base) & ~mg_dc) == 16'h0000);
    endfunction : mg_hit

    // Frame buffer window within A[31:20]
    wire logic [11:0] fb_start = fb_r[brdc_pkg::FB_START_LSB +: 12];
    wire logic [11:0] fb_dc = {7'h00, fb_size_mask(fb_r[4:0])};
    wire logic fb_on = fb_r[brdc_pkg::FB_EN_BIT] && (fb_start != 12'h000);
    function automatic logic fb_hit(input logic [35:0] a);
        fb_hit = fb_on && (a[35:32] == 4'h0) && (((a[31:20] ^ fb_start) & ~fb_dc) == 12'h000);
    endfunction : fb_hit

    // VGA window gets frame buffer handling when enabled
    function automatic logic vga_fb(input logic [35:0] a);
        vga_fb = fb_r[brdc_pkg::FB_VGA_BIT]
            && ((a[35:17] & brdc_pkg::VGA_MASK_A17) == (brdc_pkg::VGA_BASE_A17 & brdc_pkg::VGA_MASK_A17));
    endfunction : vga_fb

    // High memory gap, inclusive start to end in 1 MB steps
    wire logic [15:0] hg_start = hgs_r[15:0];
    wire logic hg_on = hgs_r[brdc_pkg::HG_EN_BIT] && (hg_start != 16'h0000);
    function automatic logic hg_hit(input logic [35:0] a);
        hg_hit = hg_on && (a[35:20] >= hg_start) && (a[35:20] <= hge_r[15:0]);
    endfunction : hg_hit

    // I/O windows on A[15:4]; result is enable bit when inside
    function automatic logic [1:0] io_win(input logic [31:0] w, input logic [15:0] a);
        logic in_win;
        in_win = (a[15:4] >= w[brdc_pkg::IO_START_LSB +: 12]) && (a[15:4] <= w[brdc_pkg::IO_END_LSB +: 12]);
        io_win = {in_win, w[brdc_pkg::IO_EN_BIT]};
    endfunction : io_win

    // Claim decision: does the bridge own this address for PCI
    function automatic logic claims(input brdc_pkg::brdc_req_t r);
        logic [1:0] w1;
        logic [1:0] w2;
        w1 = io_win(io1_r, r.addr[15:0]);
        w2 = io_win(io2_r, r.addr[15:0]);
        if (r.is_io) begin
            if (w1[1]) claims = w1[0];
            else if (w2[1]) claims = w2[0];
            else claims = COMPAT;
        end else begin
            claims = mg_hit(r.addr) || fb_hit(r.addr) || hg_hit(r.addr);
        end
    endfunction : claims

    // Host side routing; PCI side takes the opposite decision
    wire logic host_claim = host_req.valid && claims(host_req);
    wire logic host_fb = !host_req.is_io && (fb_hit(host_req.addr) || vga_fb(host_req.addr));
    wire logic fb_nolock = host_fb && fb_r[brdc_pkg::FB_NOLOCK_BIT];
    wire logic fb_noflush = host_fb && fb_r[brdc_pkg::FB_NOFLUSH_BIT] && !host_req.deferred;

    // VGA accesses carry the handling attributes; their routing is decided elsewhere
    wire logic host_vga = host_req.valid && !host_req.is_io && vga_fb(host_req.addr);
    wire logic host_handled = host_claim || host_vga;

    always_comb begin
        host_route.to_pci = host_claim;
        host_route.exclusive = host_handled && host_req.locked && !fb_nolock;
        host_route.flush_inbound = host_handled && !host_req.is_io && !fb_noflush;
    end
    assign pci_to_host = pci_req.valid && !claims(pci_req);

    // Shutdown init request, gated by the external control setting
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) init_req <= 1'b0;
        else init_req <= COMPAT && ev_shutdown && init_on_shutdown;
    end

    // PCI reset pulse: asserted through device reset, and on a 0-to-1 write
    brdc_pkg::brdc_rst_state_t rst_st_r;
    brdc_pkg::brdc_rst_state_t rst_st_nxt;
    logic [31:0] rst_cnt_r;
    logic [31:0] rst_cnt_nxt;
    logic prst_q_r;
    wire logic prst_rise = prst_r[0] && !prst_q_r;

    always_comb begin
        rst_st_nxt = rst_st_r;
        rst_cnt_nxt = rst_cnt_r;
        case (rst_st_r)
            brdc_pkg::BRDC_RST_POWER,
            brdc_pkg::BRDC_RST_PULSE: begin
                if (rst_cnt_r >= 32'(RST_CYCLES - 1)) begin
                    rst_st_nxt = brdc_pkg::BRDC_RST_IDLE;
                    rst_cnt_nxt = 32'h0;
                end else begin
                    rst_cnt_nxt = rst_cnt_r + 32'h1;
                end
            end
            brdc_pkg::BRDC_RST_IDLE: begin
                if (prst_rise) begin
                    rst_st_nxt = brdc_pkg::BRDC_RST_PULSE;
                    rst_cnt_nxt = 32'h0;
                end
            end
            default: begin
                rst_st_nxt = brdc_pkg::BRDC_RST_POWER;
                rst_cnt_nxt = 32'h0;
            end
        endcase
    end

    // Reset pulse state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_st_r <= brdc_pkg::BRDC_RST_POWER;
            rst_cnt_r <= 32'h0;
            prst_q_r <= 1'b0;
            pci_reset_out_n <= 1'b0;
        end else begin
            rst_st_r <= rst_st_nxt;
            rst_cnt_r <= rst_cnt_nxt;
            prst_q_r <= prst_r[0];
            pci_reset_out_n <= (rst_st_nxt == brdc_pkg::BRDC_RST_IDLE);
        end
    end
endmodule : brdc_top
`default_nettype wire

// *** bench/brdc_assertions.sv ***
// Checker for the range decode block, bound to the ports of its top.
// Assumes one clock and the register port timing of the design.
`timescale 1ns/100ps
`default_nettype none
module brdc_checker #(
    parameter bit COMPAT = 1'b1,
    parameter int RST_CYCLES = 20
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [brdc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire logic ev_wr_perr,
    input wire logic ev_rd_par_bad,
    input wire logic ev_shutdown,
    input wire logic init_on_shutdown,
    input wire logic init_req,
    input wire brdc_pkg::brdc_req_t host_req,
    input wire brdc_pkg::brdc_route_t host_route,
    input wire brdc_pkg::brdc_req_t pci_req,
    input wire logic pci_to_host,
    input wire logic pci_reset_out_n
);
    logic shadow_r;
    int low_cnt_r;
    // Mirror of the reset control bit, length of the low phase
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            shadow_r <= 1'b0;
            low_cnt_r <= 0;
        end else begin
            if (reg_wr && reg_addr == 10'h270) shadow_r <= reg_wdata[0];
            low_cnt_r <= pci_reset_out_n ? 0 : low_cnt_r + 1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    AST_FLAG_RD: assert property (ev_rd_par_bad ##1 (reg_rd && reg_addr == 10'h1c4) |=> reg_rdata[5])
        else $error("read parity flag missing");
    AST_FLAG_WR: assert property (ev_wr_perr ##1 (reg_rd && reg_addr == 10'h1c4) |=> reg_rdata[6])
        else $error("write parity flag missing");
    AST_ERR_RSVD: assert property ($past(reg_rd) && $past(reg_addr) == 10'h1c4 |-> (reg_rdata & 32'hffffff8e) == 32'h0)
        else $error("reserved status bits not zero");
    AST_INIT_GO: assert property (COMPAT && ev_shutdown && init_on_shutdown |=> init_req)
        else $error("init request missing");
    AST_INIT_WHY: assert property (init_req |-> $past(ev_shutdown) && $past(init_on_shutdown))
        else $error("init request without shutdown");
    AST_PULSE_GO: assert property (reg_wr && reg_addr == 10'h270 && reg_wdata[0] && !shadow_r && pci_reset_out_n
        |-> ##2 !pci_reset_out_n)
        else $error("bus reset pulse did not start");
    AST_PULSE_LEN: assert property ($rose(pci_reset_out_n) |-> low_cnt_r >= RST_CYCLES)
        else $error("bus reset pulse too short");
    AST_HOST_IDLE: assert property (!host_req.valid |-> host_route == 3'b000)
        else $error("route given for idle host");
    AST_PCI_IDLE: assert property (!pci_req.valid |-> !pci_to_host)
        else $error("idle pci access forwarded");
    AST_EXCL: assert property (host_route.exclusive |-> host_req.locked)
        else $error("exclusive access for unlocked request");
endmodule : brdc_checker
`default_nettype wire

// *** bench/brdc_far_agents.sv ***
// Host and PCI masters: present accesses and raise error events.
// Assumes bench commands change just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module brdc_far_agents (
    input wire logic clk,
    input wire logic go,
    input wire logic [3:0] fire,
    input wire logic [38:0] want,
    output brdc_pkg::brdc_req_t host_req,
    output brdc_pkg::brdc_req_t pci_req,
    output logic [3:0] ev
);
    logic [35:0] last_r = 36'h0;
    // One-cycle error events, remembered address of the last access
    always @(posedge clk) begin
        ev <= fire;
        if (go) last_r <= want[35:0];
    end
    // Released bus shows the inverted last address
    assign host_req = go ? {1'b1, want} : {4'h0, ~last_r};
    assign pci_req = host_req;
endmodule : brdc_far_agents
`default_nettype wire

// *** bench/brdc_tb_top.sv ***
// Self-checking bench for the range decode and reset control block.
// Assumes the design files and the far-side agents are compiled first.
`timescale 1ns/100ps
`default_nettype none
module brdc_tb_top;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [9:0] reg_addr = 10'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic init_on_shutdown = 1'b1;
    logic go = 1'b0;
    logic [3:0] fire = 4'h0;
    logic [38:0] want = 39'h0;
    logic [31:0] rdata, rdata_aux, seen, seen_aux;
    logic [3:0] ev;
    logic init_req, pci_to_host, prst_n, p2h_aux;
    brdc_pkg::brdc_req_t host_req, pci_req;
    brdc_pkg::brdc_route_t route;
    int miscompares = 0;
    int checks_done = 0;
    int n;
    logic [7:0] idx [9] = '{8'h71, 8'h78, 8'h7a, 8'h7c, 8'h88, 8'h8c, 8'h98, 8'h9c, 8'ha0};
    logic [31:0] rstv [9] = '{0, 0, 0, 0, 0, 0, 32'hfff00001, 0, 32'hfff00001};
    logic [31:0] msk [9] = '{0, 32'hfcf0, 32'hfff, 32'hfff01a9f, 32'h8000ffff, 32'hffff, 32'hfff0fff1, 1, 32'hfff0fff1};
    // Clock of 10 ns
    always #5 clk = ~clk;
    brdc_top #(.COMPAT(1'b1), .RST_CYCLES(20)) dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .ev_wr_perr(ev[3]),
        .ev_rd_par_bad(ev[2]), .ev_addr_par_bad(ev[1]), .ev_shutdown(ev[0]), .init_on_shutdown(init_on_shutdown),
        .init_req(init_req), .host_req(host_req), .host_route(route), .pci_req(pci_req),
        .pci_to_host(pci_to_host), .pci_reset_out_n(prst_n));
    brdc_top #(.COMPAT(1'b0), .RST_CYCLES(20)) dut_aux (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata_aux), .ev_wr_perr(ev[3]),
        .ev_rd_par_bad(ev[2]), .ev_addr_par_bad(ev[1]), .ev_shutdown(ev[0]), .init_on_shutdown(init_on_shutdown),
        .init_req(), .host_req(host_req), .host_route(), .pci_req(pci_req), .pci_to_host(p2h_aux),
        .pci_reset_out_n());
    brdc_far_agents agents (.clk(clk), .go(go), .fire(fire), .want(want), .host_req(host_req),
        .pci_req(pci_req), .ev(ev));
    // Comparison and bus tasks
    task automatic check(input string what, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : check
    task automatic wr(input logic [7:0] i, input logic [31:0] d);
        reg_addr <= {i, 2'b00};
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] i);
        reg_addr <= {i, 2'b00};
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        seen = rdata;
        seen_aux = rdata_aux;
        @(posedge clk);
    endtask : rd
    // Expected {to_pci, exclusive, flush, pci_to_host}
    task automatic dec(input logic [38:0] w, input logic [3:0] e);
        @(posedge clk);
        want <= w;
        go <= 1'b1;
        #1;
        check("decode", {28'h0, route, pci_to_host}, {28'h0, e});
    endtask : dec
    task automatic give_verdict();
        if (miscompares == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : give_verdict
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        give_verdict();
    end
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
        check("power-on pci reset active", {31'h0, prst_n}, 32'h0);
        for (int k = 0; k < 9; k++) begin
            rd(idx[k]);
            check("reset value", seen, rstv[k]);
            check("aux reset value", seen_aux, rstv[k] & 32'hfffffffe);
        end
        repeat (2) @(posedge clk);
        #1;
        check("power-on pci reset", {31'h0, prst_n}, 32'h1);
        for (int k = 0; k < 9; k++) begin
            wr(idx[k], 32'hffffffff);
            rd(idx[k]);
            check("writable bits", seen, msk[k]);
        end
        wr(8'h74, 32'hffffffff);
        rd(8'h74);
        check("unmapped", seen, 32'h0);
        for (int k = 0; k < 9; k++) wr(idx[k], 32'h0);
        fire <= 4'hf;
        @(posedge clk);
        fire <= 4'h0;
        @(posedge clk);
        #1;
        check("init request", {31'h0, init_req}, 32'h1);
        rd(8'h71);
        check("flags", seen, 32'h71);
        check("aux flags", seen_aux, 32'h70);
        wr(8'h71, 32'h0);
        rd(8'h71);
        check("flags kept", seen, 32'h71);
        wr(8'h71, 32'h20);
        rd(8'h71);
        check("one flag cleared", seen, 32'h51);
        wr(8'h71, 32'h51);
        rd(8'h71);
        check("flags cleared", seen, 32'h0);
        init_on_shutdown <= 1'b0;
        fire <= 4'h1;
        @(posedge clk);
        fire <= 4'h0;
        @(posedge clk);
        #1;
        check("init held off", {31'h0, init_req}, 32'h0);
        wr(8'h7c, 32'h10000a8f);
        dec(39'h2010f00000, 4'b1000);
        dec(39'h1010000000, 4'b1010);
        dec(39'h0011000000, 4'b0001);
        wr(8'h7c, 32'h1000088f);
        dec(39'h2010000000, 4'b1100);
        wr(8'h7c, 32'h0000088f);
        dec(39'h0000800000, 4'b0001);
        wr(8'h7a, 32'h1);
        wr(8'h78, 32'h8030);
        dec(39'h0001300000, 4'b1010);
        dec(39'h0001400000, 4'b0001);
        wr(8'h78, 32'h0030);
        dec(39'h0001300000, 4'b0001);
        wr(8'h78, 32'h8000);
        dec(39'h0001000000, 4'b0001);
        wr(8'h78, 32'hfc30);
        dec(39'h0001f00000, 4'b1010);
        dec(39'h0002000000, 4'b0001);
        wr(8'h88, 32'h80000101);
        wr(8'h8c, 32'h102);
        dec(39'h0010200000, 4'b1010);
        dec(39'h0010300000, 4'b0001);
        wr(8'h88, 32'h80000000);
        dec(39'h0005000000, 4'b0001);
        wr(8'h98, 32'h01f00100);
        dec(39'h4000000150, 4'b0001);
        dec(39'h40000001ff, 4'b0001);
        dec(39'h4000000200, 4'b1000);
        check("aux outside windows", {31'h0, p2h_aux}, 32'h1);
        wr(8'h98, 32'h01f00101);
        dec(39'h4000000150, 4'b1000);
        check("aux claimed window", {31'h0, p2h_aux}, 32'h0);
        wr(8'h78, 32'h0);
        wr(8'h7c, 32'h00001000);
        dec(39'h20000a0000, 4'b0111);
        dec(39'h2000080000, 4'b0001);
        go <= 1'b0;
        wr(8'h9c, 32'h1);
        #1;
        n = 0;
        while (prst_n !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check("pci reset length", n, 32'd20);
        wr(8'h9c, 32'h1);
        repeat (4) @(posedge clk);
        #1;
        check("no pulse while held", {31'h0, prst_n}, 32'h1);
        wr(8'h9c, 32'h0);
        wr(8'h9c, 32'h1);
        @(posedge clk);
        #1;
        check("second pulse", {31'h0, prst_n}, 32'h0);
        give_verdict();
    end
endmodule : brdc_tb_top
bind brdc_top brdc_checker #(.COMPAT(COMPAT), .RST_CYCLES(RST_CYCLES)) chk (.clk(clk), .reset_n(reset_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ev_wr_perr(ev_wr_perr), .ev_rd_par_bad(ev_rd_par_bad), .ev_shutdown(ev_shutdown),
    .init_on_shutdown(init_on_shutdown), .init_req(init_req), .host_req(host_req), .host_route(host_route),
    .pci_req(pci_req), .pci_to_host(pci_to_host), .pci_reset_out_n(pci_reset_out_n));
`default_nettype wire
